/* core/abdm_core.sv */
// Purpose: address path of the bus interface unit: A bus, AD bus, DRAM row/column mux
// Assumes: output_clock_primary is sampled on mclk; requests come from logic on mclk
// Notes: bus phases advance on rising edges of the sampled output clock
//
// Register access over APB and the register offsets were left to the implementer.
`include "abdm_regs.svh"

module abdm_core (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // internal cycle requests
  input wire logic req_valid,
  input wire abdm_pkg::abdm_req_s req,
  input wire logic refresh_req,
  output logic req_ready,
  output logic cycle_done,
  output logic [15:0] rdata,
  // pins
  input wire logic output_clock_primary,
  input wire logic address_enable_strap,
  input wire logic [15:0] ad_in,
  output logic [19:0] addr_bus,
  output logic [15:0] ad_out,
  output logic ad_oe_hi,
  output logic ad_oe_lo,
  output logic row_strobe_bank0_n,
  output logic row_strobe_bank1_n,
  output logic upper_lane_column_strobe_n,
  output logic lower_lane_column_strobe_n,
  output logic read_strobe_n,
  output logic store_strobe_n,
  output logic high_byte_write_enable_n,
  output logic low_byte_write_enable_n
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [19:0] form_addr(input abdm_pkg::abdm_req_s r);
    if (r.io)
    begin
      form_addr = r.io8 ? {`ABDM_IO8_HI, r.off[7:0]} : {4'h0, r.off};
    end
    else
    begin
      form_addr = (20'(r.seg) << `ABDM_SEG_SHIFT) + {4'h0, r.off};
    end
  endfunction

  // odd pins 1..17 carry the even bits below them for the column phase
  function automatic logic [19:0] col_addr(input logic [19:0] a);
    col_addr = a;
    for (int i = 1; i < 18; i += 2)
    begin
      col_addr[i] = a[i-1];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers and strap capture

  logic lk_s1, lk_s2, lk_s3;
  logic [15:0] adi_s1, adi_s2;
  logic strap_s1, strap_s2;
  logic strap_done, strap_low;
  logic rise, fall;

  always_ff @(posedge mclk)
  begin
    lk_s1 <= output_clock_primary;
    lk_s2 <= lk_s1;
    lk_s3 <= lk_s2;
    adi_s1 <= ad_in;
    adi_s2 <= adi_s1;
    strap_s1 <= address_enable_strap;
    strap_s2 <= strap_s1;
  end

  assign rise = lk_s2 & ~lk_s3;
  assign fall = ~lk_s2 & lk_s3;

  // strap is caught once, on the first edge after reset release
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      strap_done <= 1'b0;
      strap_low <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_done <= 1'b1;
      strap_low <= ~strap_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [`ABDM_CFG_W-1:0] cfg;
  abdm_pkg::abdm_state_e state, next_state;
  logic acc_read, hit_cfg, hit_stat;

  assign acc_read = psel & penable & ~pready;
  assign hit_cfg = paddr == `ABDM_CFG_OFS;
  assign hit_stat = paddr == `ABDM_STAT_OFS;

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= acc_read;
      if (acc_read)
      begin
        pslverr <= ~(hit_cfg | hit_stat);
        prdata <= 32'h00000000;
        if (hit_cfg)
        begin
          prdata[`ABDM_CFG_W-1:0] <= cfg;
        end
        if (hit_stat)
        begin
          prdata[`ABDM_STAT_STRAP] <= strap_low;
          prdata[`ABDM_STAT_BUSY] <= state != abdm_pkg::ST_IDLE;
          prdata[`ABDM_STAT_STATE_HI:`ABDM_STAT_STATE_LO] <= state;
        end
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      cfg <= `ABDM_CFG_RST;
    end
    else if (psel & penable & pready & pwrite & hit_cfg)
    begin
      cfg <= pwdata[`ABDM_CFG_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle sequencing

  logic [2:0] ref_cnt;
  logic start_req, start_ref;
  logic [19:0] cur_addr;
  logic cur_write, cur_bhe_n, cur_da, cur_row_strobe_bank0, cur_row_strobe_bank1;
  logic [15:0] cur_wdata;
  logic bus8;

  assign bus8 = cfg[`ABDM_CFG_BUS8];
  assign start_ref = state == abdm_pkg::ST_IDLE && rise && strap_done && refresh_req;
  assign start_req = state == abdm_pkg::ST_IDLE && rise && strap_done && !refresh_req
    && req_valid;

  always_comb
  begin
    next_state = state;
    case (state)
      abdm_pkg::ST_IDLE:
      begin
        if (start_ref)
        begin
          next_state = abdm_pkg::ST_REF;
        end
        else if (start_req)
        begin
          next_state = abdm_pkg::ST_T1;
        end
      end
      abdm_pkg::ST_T1: next_state = rise ? abdm_pkg::ST_T2 : state;
      abdm_pkg::ST_T2: next_state = rise ? abdm_pkg::ST_T3 : state;
      abdm_pkg::ST_T3: next_state = rise ? abdm_pkg::ST_T4 : state;
      abdm_pkg::ST_T4: next_state = rise ? abdm_pkg::ST_IDLE : state;
      abdm_pkg::ST_REF:
      begin
        if (rise && ref_cnt == 3'(`ABDM_REF_CLOCKS - 3'h1))
        begin
          next_state = abdm_pkg::ST_IDLE;
        end
      end
      default: next_state = abdm_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      state <= abdm_pkg::ST_IDLE;
      ref_cnt <= 3'h0;
      req_ready <= 1'b0;
    end
    else
    begin
      state <= next_state;
      req_ready <= next_state == abdm_pkg::ST_IDLE && strap_done && !start_req;
      if (start_ref)
      begin
        ref_cnt <= 3'h0;
      end
      else if (state == abdm_pkg::ST_REF && rise)
      begin
        ref_cnt <= ref_cnt + 3'h1;
      end
    end
  end

  // request capture
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      cur_addr <= 20'h00000;
      cur_write <= 1'b0;
      cur_bhe_n <= 1'b1;
      cur_da <= 1'b0;
      cur_row_strobe_bank0 <= 1'b0;
      cur_row_strobe_bank1 <= 1'b0;
      cur_wdata <= 16'h0000;
    end
    else if (start_ref)
    begin
      cur_addr <= `ABDM_ADDR_ONES;
      cur_write <= 1'b0;
    end
    else if (start_req)
    begin
      cur_addr <= form_addr(req);
      cur_write <= req.write;
      cur_bhe_n <= req.bhe_n;
      cur_wdata <= req.wdata;
      // strap low overrides both disable bits
      cur_da <= !strap_low && ((req.space == abdm_pkg::SPACE_UPPER && cfg[`ABDM_CFG_UDA])
        || (req.space == abdm_pkg::SPACE_LOWER && cfg[`ABDM_CFG_LDA]));
      cur_row_strobe_bank0 <= !req.io && req.space == abdm_pkg::SPACE_LOWER && cfg[`ABDM_CFG_DRAM0];
      cur_row_strobe_bank1 <= !req.io && req.space == abdm_pkg::SPACE_UPPER && cfg[`ABDM_CFG_DRAM1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address and data pins

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      addr_bus <= 20'h00000;
      ad_out <= 16'h0000;
      ad_oe_hi <= 1'b0;
      ad_oe_lo <= 1'b0;
      rdata <= 16'h0000;
      cycle_done <= 1'b0;
    end
    else
    begin
      cycle_done <= 1'b0;
      if (start_req)
      begin
        addr_bus <= form_addr(req);
      end
      else if (start_ref)
      begin
        ad_out <= 16'(`ABDM_ADDR_ONES);
        ad_oe_hi <= 1'b1;
        ad_oe_lo <= 1'b1;
      end
      else if (state == abdm_pkg::ST_T1 && fall)
      begin
        // AD address half an output clock after the A bus
        ad_out <= cur_addr[15:0];
        ad_oe_lo <= !cur_da;
        ad_oe_hi <= !cur_da || bus8;
      end
      else if (state == abdm_pkg::ST_T2 && rise)
      begin
        if (cur_row_strobe_bank0 || cur_row_strobe_bank1)
        begin
          addr_bus <= col_addr(cur_addr);
        end
        ad_out[7:0] <= cur_wdata[7:0];
        ad_out[15:8] <= bus8 ? cur_addr[15:8] : cur_wdata[15:8];
        ad_oe_lo <= cur_write;
        ad_oe_hi <= cur_write || bus8;
      end
      else if (state == abdm_pkg::ST_T4 && rise)
      begin
        rdata <= adi_s2;
        cycle_done <= 1'b1;
        ad_oe_hi <= 1'b0;
        ad_oe_lo <= 1'b0;
      end
      else if (state == abdm_pkg::ST_REF && fall)
      begin
        ad_oe_hi <= 1'b0;
        ad_oe_lo <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobes

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      row_strobe_bank0_n <= 1'b1;
      row_strobe_bank1_n <= 1'b1;
      upper_lane_column_strobe_n <= 1'b1;
      lower_lane_column_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      store_strobe_n <= 1'b1;
      high_byte_write_enable_n <= 1'b1;
      low_byte_write_enable_n <= 1'b1;
    end
    else if (start_ref)
    begin
      // column before row refresh, on the enabled banks only
      upper_lane_column_strobe_n <= !(cfg[`ABDM_CFG_DRAM0] || cfg[`ABDM_CFG_DRAM1]);
      lower_lane_column_strobe_n <= !(cfg[`ABDM_CFG_DRAM0] || cfg[`ABDM_CFG_DRAM1]);
    end
    else if (state == abdm_pkg::ST_REF && fall && ref_cnt == 3'h0)
    begin
      row_strobe_bank0_n <= !cfg[`ABDM_CFG_DRAM0];
      row_strobe_bank1_n <= !cfg[`ABDM_CFG_DRAM1];
    end
    else if (state == abdm_pkg::ST_T1 && fall)
    begin
      // the A bus has been valid for half a clock here
      row_strobe_bank0_n <= !cur_row_strobe_bank0;
      row_strobe_bank1_n <= !cur_row_strobe_bank1;
    end
    else if (state == abdm_pkg::ST_T2 && rise)
    begin
      read_strobe_n <= cur_write;
      store_strobe_n <= !cur_write;
      high_byte_write_enable_n <= cur_bhe_n || !cur_write;
      low_byte_write_enable_n <= cur_addr[0] || !cur_write;
    end
    else if (state == abdm_pkg::ST_T3 && rise && (cur_row_strobe_bank0 || cur_row_strobe_bank1))
    begin
      // reads open both lanes; writes only the enabled ones
      upper_lane_column_strobe_n <= cur_write && cur_bhe_n;
      lower_lane_column_strobe_n <= cur_write && cur_addr[0];
    end
    else if ((state == abdm_pkg::ST_T4 || state == abdm_pkg::ST_REF)
      && next_state == abdm_pkg::ST_IDLE)
    begin
      row_strobe_bank0_n <= 1'b1;
      row_strobe_bank1_n <= 1'b1;
      upper_lane_column_strobe_n <= 1'b1;
      lower_lane_column_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      store_strobe_n <= 1'b1;
      high_byte_write_enable_n <= 1'b1;
      low_byte_write_enable_n <= 1'b1;
    end
  end

endmodule

/* core/abdm_pkg.sv */
// Purpose: types shared by the address path
// Assumes: nothing
// Notes: one-hot state codes written out
package abdm_pkg;

  typedef enum logic [1:0]
  {
    SPACE_OTHER = 2'h0,
    SPACE_LOWER = 2'h1,
    SPACE_UPPER = 2'h2
  } abdm_space_e;

  typedef enum logic [5:0]
  {
    ST_IDLE = 6'h01,
    ST_T1 = 6'h02,
    ST_T2 = 6'h04,
    ST_T3 = 6'h08,
    ST_T4 = 6'h10,
    ST_REF = 6'h20
  } abdm_state_e;

  typedef struct packed
  {
    logic [15:0] seg;
    logic [15:0] off;
    logic io;
    logic io8;
    logic write;
    logic bhe_n;
    abdm_space_e space;
    logic [15:0] wdata;
  } abdm_req_s;

endpackage

/* core/abdm_regs.svh */
// Purpose: register offsets, field positions, reset values and counts of the address path
// Assumes: 32-bit APB, one aligned word per register
// Notes: definitions only
`ifndef ABDM_REGS_SVH
`define ABDM_REGS_SVH

`define ABDM_CFG_OFS 12'h000
`define ABDM_STAT_OFS 12'h004
`define ABDM_CFG_W 5
`define ABDM_CFG_RST 5'h00
`define ABDM_CFG_UDA 0
`define ABDM_CFG_LDA 1
`define ABDM_CFG_BUS8 2
`define ABDM_CFG_DRAM0 3
`define ABDM_CFG_DRAM1 4
`define ABDM_STAT_STRAP 0
`define ABDM_STAT_BUSY 1
`define ABDM_STAT_STATE_LO 2
`define ABDM_STAT_STATE_HI 7
`define ABDM_REF_CLOCKS 3'h7
`define ABDM_SEG_SHIFT 4
`define ABDM_ADDR_ONES 20'hFFFFF
`define ABDM_IO8_HI 12'h000

`endif

/* tb/abdm_checker.sv */
// Purpose: pin-level checks of the address path
// Assumes: bound to abdm_core, one clock domain
// Notes: sees ports only
module abdm_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // pins
  input wire logic [19:0] addr_bus,
  input wire logic [15:0] ad_out,
  input wire logic ad_oe_hi,
  input wire logic ad_oe_lo,
  input wire logic row_strobe_bank0_n,
  input wire logic lower_lane_column_strobe_n,
  input wire logic read_strobe_n,
  input wire logic store_strobe_n,
  input wire logic high_byte_write_enable_n,
  input wire logic low_byte_write_enable_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire logic quiet = read_strobe_n && store_strobe_n;
  wire logic cas = !lower_lane_column_strobe_n;
  property p_we;
    !(high_byte_write_enable_n && low_byte_write_enable_n) |->
      !store_strobe_n && (low_byte_write_enable_n || !addr_bus[0]);
  endproperty
  a_we: assert property (p_we) else $error("byte enable w/o store");
  property p_hold;
    !quiet && $past(!quiet) |-> $stable(addr_bus);
  endproperty
  a_hold: assert property (p_hold) else $error("a bus moved");
  property p_row;
    $fell(row_strobe_bank0_n) |-> addr_bus == $past(addr_bus, 2);
  endproperty
  a_row: assert property (p_row) else $error("row addr");
  property p_col;
    cas && !quiet |-> ((addr_bus[17:0] & 18'h2AAAA) >> 1) == (addr_bus[17:0] & 18'h15555);
  endproperty
  a_col: assert property (p_col) else $error("col addr");
  property p_ref;
    cas && quiet |-> $stable(addr_bus);
  endproperty
  a_ref: assert property (p_ref) else $error("refresh a bus");
  property p_ones;
    $fell(lower_lane_column_strobe_n) && quiet |-> ad_out == 16'hFFFF && ad_oe_lo && ad_oe_hi;
  endproperty
  a_ones: assert property (p_ones) else $error("refresh ones");
  property p_lead;
    $rose(ad_oe_lo) && store_strobe_n |-> addr_bus == $past(addr_bus, 4);
  endproperty
  a_lead: assert property (p_lead) else $error("a bus late");
  property p_apb;
    $rose(penable) && psel |-> !pready ##1 pready;
  endproperty
  a_apb: assert property (p_apb) else $error("apb wait");
endmodule

/* tb/abdm_mem_model.sv */
// Purpose: far-side memory on the AD pins
// Assumes: read data is a scramble of the latched address
// Notes: released lanes show the inverse of the last value
module abdm_mem_model (
  // clock
  input wire logic mclk,
  // device pins
  input wire logic [19:0] addr_bus,
  input wire logic [15:0] ad_out,
  input wire logic ad_oe_hi,
  input wire logic ad_oe_lo,
  input wire logic read_strobe_n,
  output logic [15:0] ad_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] dat = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic rd_q = 1'b1;
  always @(posedge mclk)
  begin
    rd_q <= read_strobe_n;
    if (rd_q && !read_strobe_n)
      dat <= addr_bus[15:0] ^ 16'hC35A;
    last <= ad_in;
  end
  always_comb
  begin
    ad_in = ~last;
    if (!read_strobe_n)
      ad_in = dat;
    if (ad_oe_lo)
      ad_in[7:0] = ad_out[7:0];
    if (ad_oe_hi)
      ad_in[15:8] = ad_out[15:8];
  end
endmodule

/* tb/tb_address_bus_dram_mux.sv */
// Purpose: self-checking bench of the address path
// Assumes: mclk 40 ns, output clock 320 ns free running
// Notes: random cycles per config, refresh, strap-low rerun
`include "abdm_regs.svh"
module tb_address_bus_dram_mux;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic req_valid = 1'b0;
  abdm_pkg::abdm_req_s req = '0;
  logic refresh_req = 1'b0;
  logic cycle_done;
  logic req_ready;
  logic row_strobe_bank1_n;
  logic upper_lane_column_strobe_n;
  logic [15:0] rdata;
  logic output_clock_primary = 1'b0;
  logic address_enable_strap = 1'b1;
  logic [15:0] ad_in;
  logic [19:0] addr_bus;
  logic [15:0] ad_out;
  logic ad_oe_hi;
  logic ad_oe_lo;
  logic row_strobe_bank0_n;
  logic lower_lane_column_strobe_n;
  logic read_strobe_n;
  logic store_strobe_n;
  logic high_byte_write_enable_n;
  logic low_byte_write_enable_n;
  int miscompares = 0;
  int total_checks = 0;
  int seed = 32'haf69ca96;
  int ticks = 0;
  logic [4:0] cfg = 5'h00;
  bit strap_lo = 0;
  abdm_core DUT (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .req_valid, .req, .refresh_req, .req_ready, .cycle_done, .rdata,
    .output_clock_primary, .address_enable_strap, .ad_in, .addr_bus, .ad_out, .ad_oe_hi,
    .ad_oe_lo, .row_strobe_bank0_n, .row_strobe_bank1_n, .upper_lane_column_strobe_n,
    .lower_lane_column_strobe_n, .read_strobe_n, .store_strobe_n, .high_byte_write_enable_n,
    .low_byte_write_enable_n);
  abdm_mem_model u_mem (.mclk, .addr_bus, .ad_out, .ad_oe_hi, .ad_oe_lo, .read_strobe_n,
    .ad_in);
  initial
  begin
    forever #20 mclk = ~mclk;
  end
  // odd offset keeps the bus phase clock edges off the mclk edges
  initial
  begin
    #7;
    forever #160 output_clock_primary = ~output_clock_primary;
  end
  always @(posedge mclk)
  begin
    ticks <= ticks + 1;
    if (ticks == 20000)
    begin
      miscompares = miscompares + 1;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task ck(input bit ok, input string m);
    total_checks = total_checks + 1;
    if (!ok)
    begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [19:0] colx(input logic [19:0] a);
    logic [19:0] c;
    c = a;
    for (int k = 0; k < 9; k++)
      c[2*k+1] = a[2*k];
    return c;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task cyc(input abdm_pkg::abdm_req_s r);
    logic [19:0] pa;
    logic [19:0] ab;
    logic [19:0] m;
    bit dram, drv, sa, ok, hw, lw, r0, r1, uc, lc;
    int n;
    pa = {r.seg, 4'h0} + {4'h0, r.off};
    if (r.io)
      pa = r.io8 ? {12'h000, r.off[7:0]} : {4'h0, r.off};
    m = r.io ? 20'h0FFFF : 20'hFFFFF;
    dram = (r.space == abdm_pkg::SPACE_LOWER) ? cfg[3]
      : (r.space == abdm_pkg::SPACE_UPPER) && cfg[4];
    drv = strap_lo || !((r.space == abdm_pkg::SPACE_UPPER) ? cfg[0] : (r.space == 2'h1) && cfg[1]);
    {sa, ok, hw, lw, r0, r1, uc, lc, n, ab} = {8'h40, 32'h0, 20'h0};
    @(posedge mclk);
    req <= r;
    req_valid <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (ad_oe_lo && read_strobe_n && store_strobe_n)
      begin
        sa = 1;
        ok &= ad_out === pa[15:0];
      end
      if (!(read_strobe_n && store_strobe_n))
      begin
        ab = addr_bus;
        ok &= !cfg[2] || (ad_oe_hi === 1'b1 && ad_out[15:8] === pa[15:8]);
        hw |= !high_byte_write_enable_n;
        lw |= !low_byte_write_enable_n;
      end
      r0 |= !row_strobe_bank0_n;
      r1 |= !row_strobe_bank1_n;
      uc |= !upper_lane_column_strobe_n;
      lc |= !lower_lane_column_strobe_n;
    end
    while (cycle_done !== 1'b1 && n < 200);
    req_valid <= 1'b0;
    pa = dram ? colx(pa) : pa;
    ck(n < 200 && ok, "ad address");
    ck(sa == drv, "ad drive");
    ck((ab & m) === (pa & m), "a bus");
    ck(hw == (r.write && !r.bhe_n) && lw == (r.write && !pa[0]), "byte enables");
    ck({r0, r1} == {dram && !r.space[1], dram && r.space[1]}, "row strobes");
    ck({uc, lc} == ({2{dram}} & ~{r.write && r.bhe_n, r.write && pa[0]}), "cas");
    pa[15:0] = pa[15:0] ^ 16'hC35A;
    if (!r.write)
      ck(rdata[7:0] === pa[7:0] && (cfg[2] || rdata[15:8] === pa[15:8]), "rdata");
  endtask
  task rnd(input bit io, input bit edge_case);
    logic [63:0] v;
    abdm_pkg::abdm_req_s r;
    v = {$random(seed), $random(seed)};
    r = v[53:0];
    r.io = io;
    r.io8 = io && v[60];
    if (r.space == 2'h3 || io)
      r.space = abdm_pkg::SPACE_OTHER;
    if (io && (r.io8 || r.off[15:8] == 8'h00) && r.off[7:3] == 5'h1F)
      r.off[7:0] = 8'h10;
    if (edge_case)
      {r.seg, r.off} = 32'hFFFFFFFF;
    cyc(r);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] q;
    logic e;
    logic [4:0] cl [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 16, 24, 11};
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    apb(0, `ABDM_CFG_OFS, 0, q, e);
    ck(q === 32'h00000000 && e === 1'b0, "cfg reset");
    ck(req_ready === 1'b1, "ready after reset");
    apb(0, `ABDM_STAT_OFS, 0, q, e);
    ck(q === 32'h00000004, "status idle");
    apb(1, `ABDM_CFG_OFS, 32'hFFFFFFFF, q, e);
    apb(0, `ABDM_CFG_OFS, 0, q, e);
    ck(q === 32'h0000001F, "cfg rw");
    apb(1, 12'h008, 32'hFFFFFFFF, q, e);
    apb(0, 12'h008, 0, q, e);
    ck(q === 32'h00000000 && e === 1'b1, "unmapped");
    foreach (cl[i])
    begin
      cfg = cl[i];
      apb(1, `ABDM_CFG_OFS, {27'h0, cfg}, q, e);
      repeat (4) rnd(0, i == 0);
      rnd(1, 0);
    end
    @(posedge mclk);
    refresh_req <= 1'b1;
    for (int n = 0; n < 100 && lower_lane_column_strobe_n !== 1'b0; n++)
      @(posedge mclk);
    refresh_req <= 1'b0;
    q = 0;
    while (lower_lane_column_strobe_n === 1'b0 && q < 100)
    begin
      @(posedge mclk);
      q++;
    end
    ck(q >= 54 && q <= 58, "refresh length");
    address_enable_strap <= 1'b0;
    nrst <= 1'b0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    strap_lo = 1;
    apb(0, `ABDM_STAT_OFS, 0, q, e);
    ck(q === 32'h00000005, "strap status");
    cfg = 5'h03;
    apb(1, `ABDM_CFG_OFS, {27'h0, cfg}, q, e);
    repeat (4) rnd(0, 0);
    final_report();
  end
endmodule
bind abdm_core abdm_checker u_chk (.mclk, .nrst, .psel, .penable, .pready, .addr_bus, .ad_out,
  .ad_oe_hi, .ad_oe_lo, .row_strobe_bank0_n, .lower_lane_column_strobe_n, .read_strobe_n,
  .store_strobe_n, .high_byte_write_enable_n, .low_byte_write_enable_n);
